// *** dv/fmmc_checker.sv ***
// Concurrent checks on the ports of the FM/MFM disk codec
`timescale 1ns/1ps
`default_nettype none
module fmmc_checker
	import fmmc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic mode_mfm,
	input wire logic wr_pulse,
	input wire logic rd_locked,
	input wire logic [7:0] rd_byte,
	input wire logic rd_byte_valid,
	input wire logic rd_byte_mark,
	input wire logic rd_field_addr,
	input wire logic rd_field_end,
	input wire logic rd_crc_err,
	input wire logic rd_code_err
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	localparam logic [4:0] PULSE_RUN = 5'(PULSE_CYC);
	localparam logic [4:0] RUN_SAT = 5'h1F;
	logic [4:0] hi_run;

	// Length of the current write pulse, counted so the width check stays short
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			hi_run <= 5'h00;
		else if (!wr_pulse)
			hi_run <= 5'h00;
		else if (hi_run != RUN_SAT)
			hi_run <= 5'(hi_run + 5'h01);
	end

	// Flux pulse: falls after the fixed width, then a rest before any neighbour
	sequence s_pulse_on;
		##[1:15] ($fell(wr_pulse) && hi_run == PULSE_RUN);
	endsequence
	sequence s_pulse_rest;
		!wr_pulse [*8];
	endsequence

	a_pulse_shape: assert property ($rose(wr_pulse) |-> s_pulse_on ##0 s_pulse_rest)
		else $error("write pulse width or spacing wrong");
	a_mark_byte: assert property (rd_byte_mark |-> rd_byte_valid && rd_byte == MARK_BYTE)
		else $error("mark flag without mark byte");
	a_byte_locked: assert property (rd_byte_valid |-> $past(rd_locked))
		else $error("byte decoded while unlocked");
	// Bytes are eight cells apart, so a second strobe soon after is a fault
	a_byte_single: assert property (rd_byte_valid |=> !rd_byte_valid [*8])
		else $error("byte strobe repeated");
	a_end_unlock: assert property (rd_field_end |-> !rd_locked ##1 !rd_field_end)
		else $error("field end while still locked");
	// Error flag moves only at a field end or a new mark
	a_crc_hold: assert property ($changed(rd_crc_err) |-> rd_field_end || $past(rd_field_end)
		|| rd_byte_mark || $past(rd_byte_mark))
		else $error("crc flag changed mid field");
	a_field_kind: assert property ($changed(rd_field_addr) |-> rd_byte_valid
		|| $past(rd_byte_valid))
		else $error("field kind changed without a byte");
	a_code_mode: assert property (rd_code_err |-> mode_mfm ##[0:1] !rd_locked)
		else $error("interval error outside locked MFM");
endmodule
bind fmmc_codec fmmc_checker u_chk (.ref_clk, .rstn, .mode_mfm, .wr_pulse, .rd_locked,
	.rd_byte, .rd_byte_valid, .rd_byte_mark, .rd_field_addr, .rd_field_end, .rd_crc_err,
	.rd_code_err);
`default_nettype wire

// *** dv/fmmc_codec_tb.sv ***
// Loopback testbench: write fields, read them back through the drive model
`timescale 1ns/1ps
`default_nettype none
module fmmc_codec_tb;
	import fmmc_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic mode_mfm = 1'b1;
	logic [3:0] precomp_cnt = 4'h0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic wr_mark = 1'b0;
	logic [4:0] skew = 5'h00;
	wire logic wr_ready, wr_pulse, rd_pulse, rd_locked, rd_byte_valid, rd_byte_mark;
	wire logic rd_field_addr, rd_field_end, rd_crc_err, rd_code_err;
	wire logic [7:0] rd_byte;
	logic [31:0] seed = 32'h34B3;
	logic [15:0] crc;
	logic [7:0] fb[$], exp_q[$], got[$];
	logic fm[$];
	logic ended, crc_seen, addr_seen, wr_q;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int npulse = 0;
	int nmark = 0;
	int ncode = 0;

	fmmc_codec dut (.ref_clk, .rstn, .clk_en, .mode_mfm, .precomp_cnt, .wr_valid, .wr_data,
		.wr_mark, .wr_ready, .wr_pulse, .rd_pulse, .rd_locked, .rd_byte, .rd_byte_valid,
		.rd_byte_mark, .rd_field_addr, .rd_field_end, .rd_crc_err, .rd_code_err);
	fmmc_drive_model drive (.ref_clk, .wr_pulse, .skew, .rd_pulse);

	always #10 ref_clk = ~ref_clk;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected flux pulse count of the queued bytes, one burst
	function automatic int pulses(input logic mfm);
		int n = 0;
		logic prev = 1'b0;
		foreach (fb[i])
			for (int k = 7; k >= 0; k--)
			begin
				n += fb[i][k];
				if (!(fm[i] && k == 2) && (mfm ? (!fb[i][k] && !prev) : 1'b1))
					n++;
				prev = fb[i][k];
			end
		return n;
	endfunction

	task automatic push(input logic [7:0] b, input logic mk, input logic shown);
		fb.push_back(b);
		fm.push_back(mk);
		if (shown)
			exp_q.push_back(b);
		for (int k = 7; k >= 0; k--)
			crc = (crc[15] ^ b[k]) ? {crc[14:0], 1'b0} ^ CRC_POLY : {crc[14:0], 1'b0};
	endtask

	task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_bit(input logic g, input logic e);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hold each byte until the buffer takes it; valid stays up across bytes
	task automatic send(input logic [7:0] b, input logic mk);
		wr_data = b;
		wr_mark = mk;
		wr_valid = 1'b1;
		while (wr_ready !== 1'b1)
		begin
			@(posedge ref_clk);
			#2;
		end
		@(posedge ref_clk);
		#2;
		skew = 5'(rnd() % 5);
	endtask

	// One address field: preamble, marks, type, four ids, crc, gap
	task automatic run_field(input logic mfm, input int marks, input logic bad);
		int t = 0;
		logic [15:0] c;
		fb.delete();
		fm.delete();
		exp_q.delete();
		got.delete();
		ended = 1'b0;
		mode_mfm = mfm;
		precomp_cnt = 4'(rnd() % 6);
		for (int i = 0; i < 6; i++)
			push(8'h00, 1'b0, 1'b0);
		crc = CRC_INIT;
		repeat (marks) push(MARK_BYTE, 1'b1, 1'b1);
		push(ID_TYPE, 1'b0, 1'b1);
		repeat (4) push(8'(rnd()), 1'b0, 1'b1);
		c = crc ^ {15'h0000, bad};
		push(c[15:8], 1'b0, 1'b1);
		push(c[7:0], 1'b0, 1'b1);
		push(8'h4E, 1'b0, 1'b0);
		push(8'h4E, 1'b0, 1'b0);
		npulse = 0;
		nmark = 0;
		ncode = 0;
		foreach (fb[i])
			send(fb[i], fm[i]);
		wr_valid = 1'b0;
		while (!ended && t < 4000)
		begin
			@(posedge ref_clk);
			t++;
		end
		t = 0;
		while (t < 300)
		begin
			@(posedge ref_clk);
			t = wr_pulse ? 0 : t + 1;
		end
		#2;
		cmp_bit(ended, 1'b1);
		cmp_bit(crc_seen, bad);
		cmp_bit(addr_seen, 1'b1);
		cmp_val(16'(npulse), 16'(pulses(mfm)));
		cmp_val(16'(got.size()), 16'(exp_q.size()));
		cmp_val(16'(nmark), 16'(marks));
		cmp_val(16'(ncode), 16'h0000);
		foreach (exp_q[i])
			if (i < got.size())
				cmp_val({8'h00, got[i]}, {8'h00, exp_q[i]});
	endtask

	// Monitor of read results, pulse count and the run limit
	always @(posedge ref_clk)
	begin
		cycles++;
		if (rd_byte_valid === 1'b1)
			got.push_back(rd_byte);
		if (rd_byte_mark === 1'b1)
			nmark++;
		if (rd_code_err !== 1'b0)
			ncode++;
		if (rd_field_end === 1'b1)
		begin
			ended = 1'b1;
			crc_seen = rd_crc_err;
			addr_seen = rd_field_addr;
		end
		if (wr_pulse === 1'b1 && wr_q !== 1'b1)
			npulse++;
		wr_q = wr_pulse;
		if (cycles > 75000)
		begin
			mismatches++;
			finish_test();
		end
	end

	initial
	begin
		repeat (10) @(posedge ref_clk);
		#2;
		rstn = 1'b1;
		run_field(1'b1, 3, 1'b0);
		run_field(1'b1, 1, 1'b1);
		run_field(1'b0, 1, 1'b0);
		run_field(1'b0, 2, 1'b1);
		finish_test();
	end
endmodule
`default_nettype wire

// *** dv/fmmc_drive_model.sv ***
// Drive model: plays written flux pulses back on the read line
`timescale 1ns/1ps
`default_nettype none
module fmmc_drive_model #(
	parameter int BASE_DLY = 8
) (
	input wire logic ref_clk,
	input wire logic wr_pulse,
	input wire logic [4:0] skew,
	output logic rd_pulse
);
	logic wr_q = 1'b0;
	initial rd_pulse = 1'b0;

	// Each pulse returns after a head delay; line rests low between pulses
	always @(posedge ref_clk)
	begin
		wr_q <= wr_pulse;
		if (wr_pulse && !wr_q)
			fork
				begin
					automatic int d = BASE_DLY + int'(skew);
					repeat (d) @(posedge ref_clk);
					#3 rd_pulse = 1'b1;
					repeat (4) @(posedge ref_clk);
					#3 rd_pulse = 1'b0;
				end
			join_none
	end
endmodule
`default_nettype wire

// *** verilog/fmmc_buf2.sv ***
// Two-entry valid/ready buffer in front of the write encoder
`timescale 1ns/1ps
`default_nettype none
module fmmc_buf2 #(
	parameter int W = 9,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wp, rp, next_wp, next_rp;
	logic [PW:0] cnt, next_cnt;
	logic next_in_ready;
	logic push, pop;

	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];

	// Pointer and fill bookkeeping
	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wp = push ? ((wp == LAST) ? '0 : PW'(wp + 1'b1)) : wp;
		next_rp = pop ? ((rp == LAST) ? '0 : PW'(rp + 1'b1)) : rp;
		next_cnt = cnt;
		if (push && !pop)
			next_cnt = (PW + 1)'(cnt + 1'b1);
		else if (pop && !push)
			next_cnt = (PW + 1)'(cnt - 1'b1);
		next_in_ready = (next_cnt != FULL); // Registered so the port comes from a flop
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
			in_ready <= 1'b0;
		end
		else if (clk_en)
		begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
			in_ready <= next_in_ready;
		end
	end

	// Storage holds no reset, only valid entries are read
	always_ff @(posedge ref_clk)
	begin
		if (clk_en && push)
			mem[wp] <= in_data;
	end
endmodule
`default_nettype wire

// *** verilog/fmmc_codec.sv ***
// FM/MFM disk pulse codec: encoder with MFM-only write precompensation and field-aware decoder
`timescale 1ns/1ps
`default_nettype none
module fmmc_codec
	import fmmc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic mode_mfm,
	input wire logic [3:0] precomp_cnt,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic wr_mark,
	output logic wr_ready,
	output logic wr_pulse,
	input wire logic rd_pulse,
	output logic rd_locked,
	output logic [7:0] rd_byte,
	output logic rd_byte_valid,
	output logic rd_byte_mark,
	output logic rd_field_addr,
	output logic rd_field_end,
	output logic rd_crc_err,
	output logic rd_code_err
);
	// Write side
	logic b_valid, b_ready;
	logic [8:0] b_data;
	logic e_busy, next_e_busy;
	logic [7:0] e_sr, next_e_sr;
	logic e_mark, next_e_mark;
	logic [2:0] e_bit, next_e_bit;
	logic [6:0] e_cnt, next_e_cnt;
	logic e_prev, next_e_prev;
	logic [3:0] e_tmr, next_e_tmr;
	logic next_wr_pulse;
	logic cur, nxt, clk_need, early, late, fire;
	logic [6:0] pc, dpos;

	// Two-entry buffer absorbs the gap between bytes without stalling the cell timing
	fmmc_buf2 #(.W(9), .DEPTH(2)) u_buf (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.in_valid(wr_valid),
		.in_data({wr_mark, wr_data}),
		.in_ready(wr_ready),
		.out_valid(b_valid),
		.out_data(b_data),
		.out_ready(b_ready)
	);

	// Encoder next state: one cell per CELL_CYC clocks, MSB first
	always_comb
	begin
		cur = e_sr[e_bit];
		if (e_bit != 3'h0)
			nxt = e_sr[3'(e_bit - 3'h1)];
		else
			nxt = b_valid && b_data[7];
		clk_need = mode_mfm ? (!cur && !e_prev) : 1'b1;
		if (e_mark && e_bit == MARK_BIT)
			clk_need = 1'b0;
		// Neighbour on the left pushes a pulse late, so write it early
		early = mode_mfm && e_prev && !nxt;
		late = mode_mfm && !e_prev && nxt;
		pc = {3'h0, precomp_cnt};
		if (early)
			dpos = W_DATA_POS - pc;
		else if (late)
			dpos = W_DATA_POS + pc;
		else
			dpos = W_DATA_POS;
		fire = e_busy && ((e_cnt == W_CLK_POS && clk_need) || (cur && e_cnt == dpos));
		next_e_tmr = fire ? PULSE_CYC : ((e_tmr != 4'h0) ? 4'(e_tmr - 4'h1) : 4'h0);
		next_wr_pulse = fire || (e_tmr > 4'h1);
		b_ready = !e_busy || (e_cnt == CELL_LAST && e_bit == 3'h0);
		next_e_busy = e_busy;
		next_e_sr = e_sr;
		next_e_mark = e_mark;
		next_e_bit = e_bit;
		next_e_cnt = e_cnt;
		next_e_prev = e_prev;
		if (!e_busy)
		begin
			next_e_prev = 1'b0;
			next_e_cnt = 7'h00;
			if (b_valid)
			begin
				next_e_busy = 1'b1;
				{next_e_mark, next_e_sr} = b_data;
				next_e_bit = 3'h7;
			end
		end
		else if (e_cnt == CELL_LAST)
		begin
			next_e_cnt = 7'h00;
			next_e_prev = cur;
			if (e_bit != 3'h0)
				next_e_bit = 3'(e_bit - 3'h1);
			else if (b_valid)
			begin
				{next_e_mark, next_e_sr} = b_data;
				next_e_bit = 3'h7;
			end
			else
				next_e_busy = 1'b0;
		end
		else
			next_e_cnt = 7'(e_cnt + 7'h01);
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			e_busy <= 1'b0;
			e_sr <= 8'h00;
			e_mark <= 1'b0;
			e_bit <= 3'h0;
			e_cnt <= 7'h00;
			e_prev <= 1'b0;
			e_tmr <= 4'h0;
			wr_pulse <= 1'b0;
		end
		else if (clk_en)
		begin
			e_busy <= next_e_busy;
			e_sr <= next_e_sr;
			e_mark <= next_e_mark;
			e_bit <= next_e_bit;
			e_cnt <= next_e_cnt;
			e_prev <= next_e_prev;
			e_tmr <= next_e_tmr;
			wr_pulse <= next_wr_pulse;
		end
	end

	// Read side
	logic s1, s2, s3;
	logic [6:0] rph, next_rph;
	logic clk_seen, next_clk_seen, dat_seen, next_dat_seen;
	logic [7:0] ivl, next_ivl, lock_cnt, next_lock_cnt;
	logic [15:0] raw, next_raw, crc, next_crc;
	logic [7:0] sh, next_sh;
	logic [2:0] bitn, next_bitn;
	logic [9:0] bcnt, next_bcnt;
	fmmc_fstate_t fstate, next_fstate;
	fmmc_ivl_t ivl_cls;
	logic next_rd_locked, next_rd_byte_valid, next_rd_byte_mark, next_rd_field_addr;
	logic next_rd_field_end, next_rd_crc_err, next_rd_code_err;
	logic [7:0] next_rd_byte;
	logic edge_seen, in_clk, cell_end, c_bit, d_bit;
	logic [6:0] ctr;
	logic signed [7:0] err;
	logic [7:0] corr;
	logic [15:0] raw_n, crc_n, mark_raw;
	logic [7:0] byte_n;

	// Decoder next state: digital phase tracking, lock, field walk
	always_comb
	begin
		edge_seen = s2 && !s3;
		in_clk = rph < HALF_CYC;
		ctr = in_clk ? QTR_CYC : 7'(HALF_CYC + QTR_CYC); // Window centres, a quarter cell each side
		err = $signed({1'b0, rph}) - $signed({1'b0, ctr});
		corr = 8'({1'b0, rph} + 8'h01 - 8'(err >>> 1));
		c_bit = clk_seen || (edge_seen && in_clk);
		d_bit = dat_seen || (edge_seen && !in_clk);
		cell_end = !edge_seen && rph == CELL_LAST;
		raw_n = {raw[13:0], c_bit, d_bit};
		byte_n = {sh[6:0], d_bit};
		crc_n = fmmc_crc_byte(crc, byte_n);
		mark_raw = mode_mfm ? MFM_MARK_RAW : FM_MARK_RAW;
		if (ivl < IVL_LO)
			ivl_cls = IVL_BAD;
		else if (ivl < IVL_MID)
			ivl_cls = IVL_ONE;
		else if (ivl < IVL_HI)
			ivl_cls = IVL_ONE_HALF;
		else if (ivl < IVL_MAX)
			ivl_cls = IVL_TWO;
		else
			ivl_cls = IVL_BAD;
		next_rph = 7'(rph + 7'h01); // Free run holds the rate when no pulse
		next_clk_seen = clk_seen;
		next_dat_seen = dat_seen;
		next_ivl = edge_seen ? 8'h00 : ((ivl == IVL_SAT) ? ivl : 8'(ivl + 8'h01));
		next_lock_cnt = lock_cnt;
		next_raw = raw;
		next_crc = crc;
		next_sh = sh;
		next_bitn = bitn;
		next_bcnt = bcnt;
		next_fstate = fstate;
		next_rd_locked = rd_locked;
		next_rd_byte = rd_byte;
		next_rd_byte_valid = 1'b0;
		next_rd_byte_mark = 1'b0;
		next_rd_field_addr = rd_field_addr;
		next_rd_field_end = 1'b0;
		next_rd_crc_err = rd_crc_err;
		next_rd_code_err = 1'b0;
		if (edge_seen)
		begin
			// Pull phase half way toward the window centre
			next_rph = corr[6:0];
			next_clk_seen = c_bit;
			next_dat_seen = d_bit;
			if (rd_locked && mode_mfm && ivl_cls == IVL_BAD)
			begin
				// Interval fits no class: drop lock and hunt again
				next_rd_code_err = 1'b1;
				next_fstate = F_HUNT;
				next_rd_locked = 1'b0;
				next_lock_cnt = 8'h00;
			end
		end
		else if (cell_end)
		begin
			next_rph = 7'h00;
			next_clk_seen = 1'b0;
			next_dat_seen = 1'b0;
			next_raw = raw_n;
			next_sh = byte_n;
			if (fstate == F_HUNT)
			begin
				// Preamble cell: clock present, data empty
				if (c_bit && !d_bit)
				begin
					if (lock_cnt == 8'(LOCK_CELLS - 8'h01))
					begin
						next_rd_locked = 1'b1;
						next_fstate = F_MARK;
						next_lock_cnt = 8'h00;
					end
					else
						next_lock_cnt = 8'(lock_cnt + 8'h01);
				end
				else
				begin
					next_lock_cnt = 8'h00;
					// Data-only cell: frame is half a cell off, so slip it
					if (d_bit && !c_bit)
						next_rph = HALF_CYC;
				end
			end
			else if ((fstate == F_MARK || fstate == F_TYPE) && raw_n == mark_raw)
			begin
				// Missing-clock pattern aligns the byte boundary
				next_bitn = 3'h0;
				next_crc = fmmc_crc_byte((fstate == F_MARK) ? CRC_INIT : crc, MARK_BYTE);
				if (fstate == F_MARK)
					next_rd_crc_err = 1'b0;
				next_rd_byte = MARK_BYTE;
				next_rd_byte_valid = 1'b1;
				next_rd_byte_mark = 1'b1;
				next_fstate = F_TYPE;
			end
			else if (fstate != F_MARK)
			begin
				if (bitn != 3'h7)
					next_bitn = 3'(bitn + 3'h1);
				else
				begin
					next_bitn = 3'h0;
					next_rd_byte = byte_n;
					next_rd_byte_valid = 1'b1;
					next_crc = crc_n;
					next_bcnt = 10'(bcnt - 10'h001);
					case (fstate)
						F_TYPE:
						begin
							if (byte_n == ID_TYPE)
							begin
								next_rd_field_addr = 1'b1;
								next_bcnt = ID_BYTES;
								next_fstate = F_BODY;
							end
							else if (byte_n == DATA_TYPE)
							begin
								next_rd_field_addr = 1'b0;
								next_bcnt = SECTOR_BYTES;
								next_fstate = F_BODY;
							end
							else
							begin
								next_fstate = F_HUNT;
								next_rd_locked = 1'b0;
							end
						end
						F_BODY:
						begin
							if (bcnt == 10'h001)
							begin
								next_bcnt = CRC_BYTES;
								next_fstate = F_CRC;
							end
						end
						F_CRC:
						begin
							if (bcnt == 10'h001)
							begin
								// Gap follows: relock on the next preamble
								next_rd_field_end = 1'b1;
								next_rd_crc_err = (crc_n != CRC_GOOD);
								next_fstate = F_HUNT;
								next_rd_locked = 1'b0;
							end
						end
						default:
						begin
							next_fstate = F_HUNT;
							next_rd_locked = 1'b0;
						end
					endcase
				end
			end
		end
	end

	// Read pin passes two flops, third flop feeds the edge detector
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			rph <= 7'h00;
			clk_seen <= 1'b0;
			dat_seen <= 1'b0;
			ivl <= 8'h00;
			lock_cnt <= 8'h00;
			raw <= 16'h0000;
			crc <= CRC_INIT;
			sh <= 8'h00;
			bitn <= 3'h0;
			bcnt <= 10'h000;
			fstate <= F_HUNT;
			rd_locked <= 1'b0;
			rd_byte <= 8'h00;
			rd_byte_valid <= 1'b0;
			rd_byte_mark <= 1'b0;
			rd_field_addr <= 1'b0;
			rd_field_end <= 1'b0;
			rd_crc_err <= 1'b0;
			rd_code_err <= 1'b0;
		end
		else if (clk_en)
		begin
			s1 <= rd_pulse;
			s2 <= s1;
			s3 <= s2;
			rph <= next_rph;
			clk_seen <= next_clk_seen;
			dat_seen <= next_dat_seen;
			ivl <= next_ivl;
			lock_cnt <= next_lock_cnt;
			raw <= next_raw;
			crc <= next_crc;
			sh <= next_sh;
			bitn <= next_bitn;
			bcnt <= next_bcnt;
			fstate <= next_fstate;
			rd_locked <= next_rd_locked;
			rd_byte <= next_rd_byte;
			rd_byte_valid <= next_rd_byte_valid;
			rd_byte_mark <= next_rd_byte_mark;
			rd_field_addr <= next_rd_field_addr;
			rd_field_end <= next_rd_field_end;
			rd_crc_err <= next_rd_crc_err;
			rd_code_err <= next_rd_code_err;
		end
	end
endmodule
`default_nettype wire

// *** verilog/fmmc_pkg.sv ***
// Constants, types and the CRC helper for the FM/MFM disk codec
package fmmc_pkg;

	// Bit cell timing at the 50 MHz system clock
	localparam int CLK_NS = 20;
	localparam int CELL_NS = 2000;
	localparam int CELL_CYC = CELL_NS / CLK_NS;
	localparam int PULSE_NS = 200;
	localparam int PULSE_CYC_I = (PULSE_NS + CLK_NS - 1) / CLK_NS;

	localparam logic [6:0] CELL_LAST = 7'(CELL_CYC - 1);
	localparam logic [6:0] HALF_CYC = 7'(CELL_CYC / 2);
	localparam logic [6:0] QTR_CYC = 7'(CELL_CYC / 4);
	localparam logic [6:0] W_CLK_POS = 7'h14;
	localparam logic [6:0] W_DATA_POS = W_CLK_POS + HALF_CYC;
	localparam logic [3:0] PULSE_CYC = 4'(PULSE_CYC_I);

	// Pulse interval class borders: 1, 1.5 and 2 cells, each half a cell wide
	localparam logic [7:0] IVL_LO = 8'(CELL_CYC - CELL_CYC / 4);
	localparam logic [7:0] IVL_MID = 8'(CELL_CYC + CELL_CYC / 4);
	localparam logic [7:0] IVL_HI = 8'(2 * CELL_CYC - CELL_CYC / 4);
	localparam logic [7:0] IVL_MAX = 8'(2 * CELL_CYC + CELL_CYC / 4);
	localparam logic [7:0] IVL_SAT = 8'hFF;

	// Field layout
	localparam logic [7:0] LOCK_CELLS = 8'h20;
	localparam logic [9:0] ID_BYTES = 10'h004;
	localparam logic [9:0] SECTOR_BYTES = 10'h200;
	localparam logic [9:0] CRC_BYTES = 10'h002;

	// Marks and CRC
	localparam logic [7:0] MARK_BYTE = 8'hA1;
	localparam logic [7:0] ID_TYPE = 8'hFE;
	localparam logic [7:0] DATA_TYPE = 8'hFB;
	localparam logic [2:0] MARK_BIT = 3'h2;
	localparam logic [15:0] MFM_MARK_RAW = 16'h4489;
	localparam logic [15:0] FM_MARK_RAW = 16'hEE8B;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_GOOD = 16'h0000;

	typedef enum logic [2:0] {
		F_HUNT = 3'h0,
		F_MARK = 3'h1,
		F_TYPE = 3'h3,
		F_BODY = 3'h2,
		F_CRC = 3'h6
	} fmmc_fstate_t;

	typedef enum logic [1:0] {
		IVL_BAD = 2'h0,
		IVL_ONE = 2'h1,
		IVL_ONE_HALF = 2'h2,
		IVL_TWO = 2'h3
	} fmmc_ivl_t;

	// One byte of CRC, MSB first
	function automatic logic [15:0] fmmc_crc_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--)
		begin
			if (c[15] ^ b[i])
				c = {c[14:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[14:0], 1'b0};
		end
		return c;
	endfunction

endpackage
